// *** hw/pwmsf_pkg.sv ***
// Constants and types shared by the PWM software-force qualifier.
`default_nettype none
package pwmsf_pkg;
  // Register word indices on the plain register port.
  localparam int unsigned        ADDR_W          = 4;
  localparam logic [ADDR_W-1:0]  OFS_ONE_SHOT    = 4'h0;
  localparam logic [ADDR_W-1:0]  OFS_HOLD        = 4'h1;
  localparam logic [ADDR_W-1:0]  OFS_STATUS      = 4'h2;
  localparam int unsigned        DATA_W          = 16;

  // Field positions of one_shot_force_control, per output (index 0 = A, 1 = B).
  localparam int unsigned        OS_ACT_LSB [2]  = '{0, 3};
  localparam int unsigned        OS_TRIG_BIT [2] = '{2, 5};
  localparam int unsigned        OS_RELOAD_LSB   = 6;

  // Field positions of continuous_force_control, per output.
  localparam int unsigned        HOLD_LSB [2]    = '{0, 2};

  // Field positions of the status word.
  localparam int unsigned        ST_PEND_LSB     = 0;
  localparam int unsigned        ST_LEVEL_LSB    = 2;
  localparam int unsigned        ST_SHADOW_LSB   = 4;

  // Values after reset.
  localparam logic [1:0]         RST_ACTION      = 2'h0;
  localparam logic [1:0]         RST_RELOAD      = 2'h0;
  localparam logic [1:0]         RST_HOLD        = 2'h0;
  localparam logic               RST_LEVEL       = 1'h0;

  // Action encodings shared by one-shot and qualifier events.
  typedef enum logic [1:0] {
    PWMSF_ACT_NONE   = 2'h0,
    PWMSF_ACT_CLEAR  = 2'h1,
    PWMSF_ACT_SET    = 2'h2,
    PWMSF_ACT_TOGGLE = 2'h3
  } pwmsf_action_t;

  // Continuous-force encodings.
  typedef enum logic [1:0] {
    PWMSF_HOLD_OFF   = 2'h0,
    PWMSF_HOLD_LOW   = 2'h1,
    PWMSF_HOLD_HIGH  = 2'h2,
    PWMSF_HOLD_OFF2  = 2'h3
  } pwmsf_hold_t;

  // Shadow reload selections.
  typedef enum logic [1:0] {
    PWMSF_RLD_ZERO   = 2'h0,
    PWMSF_RLD_PERIOD = 2'h1,
    PWMSF_RLD_EITHER = 2'h2,
    PWMSF_RLD_DIRECT = 2'h3
  } pwmsf_reload_t;
endpackage
`default_nettype wire

// *** hw/pwmsf_top.sv ***
// PWM software-force qualifier: one-shot and continuous software forcing of outputs A and B.
//
// Function
// - One-shot force on B applies none, clear, set or toggle per its selector.
// - One-shot force on A applies none, clear, set or toggle per bits 1:0.
// - One-shot actions ignore the counter direction entirely.
// - Writing 1 to trigger bit 2 launches exactly one forced event on A.
// - Writing 0 to the A trigger does nothing; the bit always reads 0.
// - The A trigger clears itself once its write completes and the event launches.
// - Continuous force B in bits 3-2: 01 low, 10 high, else unforced.
// - Continuous force A in bits 1-0: 01 low, 10 high, else unforced.
// - Immediate mode: a written hold value acts at the next time-base edge.
// - Shadow mode: a written value acts at the edge after its shadow transfer.
// - The reload-option field selects shadow or immediate mode for the hold register.
// - Reload 00 at zero, 01 at period, 10 at either, 11 direct writes.
// - Writing 1 to trigger bit 5 launches one event on B; reads 0, self-clears.
// - A one-shot level is replaced by any later qualifier event on that output.
`default_nettype none
module pwmsf_top #(
  parameter int unsigned NUM_OUT = 2
) (
  // Clock and reset.
  input  wire logic                               clk,
  input  wire logic                               arst_n,
  // Register port.
  input  wire logic [pwmsf_pkg::ADDR_W-1:0]       reg_addr,
  input  wire logic [pwmsf_pkg::DATA_W-1:0]       reg_wdata,
  input  wire logic                               reg_wr,
  input  wire logic                               reg_rd,
  output logic      [pwmsf_pkg::DATA_W-1:0]       reg_rdata,
  // Time base.
  input  wire logic                               time_base_clock,
  input  wire logic                               cnt_zero,
  input  wire logic                               cnt_period,
  // Qualified actions from the compare and counter qualifiers, 2 bits per output.
  input  wire logic [2*NUM_OUT-1:0]               qual_action,
  // PWM outputs.
  output logic                                    pwm_out_a,
  output logic                                    pwm_out_b
);

  localparam int unsigned CH = 2;

  // Software-visible control state.
  logic [1:0]              oneshot_action_ff [CH];
  logic [1:0]              hold_force_reload_sel_ff;
  logic [1:0]              hold_shadow_ff    [CH];
  logic [1:0]              hold_active_ff    [CH];
  logic [CH-1:0]           oneshot_pend_ff;
  logic [CH-1:0]           level_ff;
  logic [CH-1:0]           out_ff;
  logic [pwmsf_pkg::DATA_W-1:0] rdata_ff;

  logic                    wr_one_shot;
  logic                    wr_hold;
  logic                    direct_mode;
  logic                    shadow_load;

  assign wr_one_shot = reg_wr && (reg_addr == pwmsf_pkg::OFS_ONE_SHOT);
  assign wr_hold     = reg_wr && (reg_addr == pwmsf_pkg::OFS_HOLD);
  assign direct_mode = (hold_force_reload_sel_ff == pwmsf_pkg::PWMSF_RLD_DIRECT);

  // Shadow transfer strobe; only counter events seen on a time-base tick count.
  always_comb begin
    unique case (pwmsf_pkg::pwmsf_reload_t'(hold_force_reload_sel_ff))
      pwmsf_pkg::PWMSF_RLD_ZERO:   shadow_load = time_base_clock && cnt_zero;
      pwmsf_pkg::PWMSF_RLD_PERIOD: shadow_load = time_base_clock && cnt_period;
      pwmsf_pkg::PWMSF_RLD_EITHER: shadow_load = time_base_clock
                                                 && (cnt_zero || cnt_period);
      pwmsf_pkg::PWMSF_RLD_DIRECT: shadow_load = 1'b0;
    endcase
  end

  // Reload selection is shared by both outputs.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_force_reload_sel_ff <= pwmsf_pkg::RST_RELOAD;
    end else if (wr_one_shot) begin
      hold_force_reload_sel_ff <= reg_wdata[pwmsf_pkg::OS_RELOAD_LSB +: 2];
    end
  end

  for (genvar i = 0; i < CH; i++) begin : g_out
    logic [1:0] q_act;
    logic [1:0] eff_act;
    logic       nxt_level;
    logic       nxt_out;
    logic       trig_wr;

    assign q_act   = qual_action[2*i +: 2];
    // Only a written 1 launches; a written 0 is ignored.
    assign trig_wr = wr_one_shot && reg_wdata[pwmsf_pkg::OS_TRIG_BIT[i]];

    // One-shot action selector.
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        oneshot_action_ff[i] <= pwmsf_pkg::RST_ACTION;
      end else if (wr_one_shot) begin
        oneshot_action_ff[i] <= reg_wdata[pwmsf_pkg::OS_ACT_LSB[i] +: 2];
      end
    end

    // Pending one-shot: the trigger bit itself is never stored, so it self-clears
    // as soon as the write completes. A new launch in the consuming tick wins.
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        oneshot_pend_ff[i] <= 1'b0;
      end else if (trig_wr) begin
        oneshot_pend_ff[i] <= 1'b1;
      end else if (time_base_clock) begin
        oneshot_pend_ff[i] <= 1'b0;
      end
    end

    // Pending one-shot takes the tick; otherwise the qualifier event applies, so a
    // later qualifier event overwrites a forced level. Direction plays no part.
    always_comb begin
      eff_act = oneshot_pend_ff[i] ? oneshot_action_ff[i] : q_act;
      unique case (pwmsf_pkg::pwmsf_action_t'(eff_act))
        pwmsf_pkg::PWMSF_ACT_NONE:   nxt_level = level_ff[i];
        pwmsf_pkg::PWMSF_ACT_CLEAR:  nxt_level = 1'b0;
        pwmsf_pkg::PWMSF_ACT_SET:    nxt_level = 1'b1;
        pwmsf_pkg::PWMSF_ACT_TOGGLE: nxt_level = ~level_ff[i];
      endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        level_ff[i] <= pwmsf_pkg::RST_LEVEL;
      end else if (time_base_clock) begin
        level_ff[i] <= nxt_level;
      end
    end

    // Shadow copy of the continuous force.
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        hold_shadow_ff[i] <= pwmsf_pkg::RST_HOLD;
      end else if (wr_hold && !direct_mode) begin
        hold_shadow_ff[i] <= reg_wdata[pwmsf_pkg::HOLD_LSB[i] +: 2];
      end
    end

    // Active continuous force: written directly in immediate mode, else loaded
    // from the shadow. A direct write wins over a coincident shadow load.
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        hold_active_ff[i] <= pwmsf_pkg::RST_HOLD;
      end else if (wr_hold && direct_mode) begin
        hold_active_ff[i] <= reg_wdata[pwmsf_pkg::HOLD_LSB[i] +: 2];
      end else if (shadow_load) begin
        hold_active_ff[i] <= hold_shadow_ff[i];
      end
    end

    // Continuous force overrides the action level; codes 00 and 11 leave it alone.
    always_comb begin
      unique case (pwmsf_pkg::pwmsf_hold_t'(hold_active_ff[i]))
        pwmsf_pkg::PWMSF_HOLD_LOW:  nxt_out = 1'b0;
        pwmsf_pkg::PWMSF_HOLD_HIGH: nxt_out = 1'b1;
        pwmsf_pkg::PWMSF_HOLD_OFF,
        pwmsf_pkg::PWMSF_HOLD_OFF2: nxt_out = nxt_level;
      endcase
    end

    // The output register moves only on time-base ticks, so any force change is
    // seen at the first tick after it reaches the active register.
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        out_ff[i] <= pwmsf_pkg::RST_LEVEL;
      end else if (time_base_clock) begin
        out_ff[i] <= nxt_out;
      end
    end
  end

  assign pwm_out_a = out_ff[0];
  assign pwm_out_b = out_ff[1];

  // Read data: trigger bits always read 0 since they are never stored.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= '0;
    end else if (reg_rd) begin
      rdata_ff <= '0;
      unique case (reg_addr)
        pwmsf_pkg::OFS_ONE_SHOT: begin
          rdata_ff[pwmsf_pkg::OS_ACT_LSB[0] +: 2]  <= oneshot_action_ff[0];
          rdata_ff[pwmsf_pkg::OS_ACT_LSB[1] +: 2]  <= oneshot_action_ff[1];
          rdata_ff[pwmsf_pkg::OS_RELOAD_LSB +: 2]  <= hold_force_reload_sel_ff;
        end
        pwmsf_pkg::OFS_HOLD: begin
          rdata_ff[pwmsf_pkg::HOLD_LSB[0] +: 2]    <= hold_active_ff[0];
          rdata_ff[pwmsf_pkg::HOLD_LSB[1] +: 2]    <= hold_active_ff[1];
        end
        pwmsf_pkg::OFS_STATUS: begin
          rdata_ff[pwmsf_pkg::ST_PEND_LSB +: 2]    <= oneshot_pend_ff;
          rdata_ff[pwmsf_pkg::ST_LEVEL_LSB +: 2]   <= out_ff;
          rdata_ff[pwmsf_pkg::ST_SHADOW_LSB +: 2]  <= hold_shadow_ff[0];
          rdata_ff[pwmsf_pkg::ST_SHADOW_LSB+2 +: 2] <= hold_shadow_ff[1];
        end
        default: begin
          rdata_ff <= '0;
        end
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule
`default_nettype wire

// *** verif/pwmsf_monitor.sv ***
// Port-level checker for the software-force qualifier.
`default_nettype none
module pwmsf_monitor (
  // Clock, reset and register port.
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Time base and outputs.
  input wire logic        time_base_clock,
  input wire logic        pwm_out_a,
  input wire logic        pwm_out_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_trig_rd; $past(reg_rd) && $past(reg_addr) == 4'h0 |-> !reg_rdata[2] && !reg_rdata[5]; endproperty
  a_trig_rd: assert property (p_trig_rd) else $error("trigger bit read back as one");
  property p_out_tick; $changed({pwm_out_b, pwm_out_a}) |-> $past(time_base_clock); endproperty
  a_out_tick: assert property (p_out_tick) else $error("output moved without a tick");
  property p_hold_a; $past(reg_rd) && $past(reg_addr) == 4'h1 && reg_rdata[1:0] == 2'h2
    ##1 time_base_clock |=> pwm_out_a; endproperty
  a_hold_a: assert property (p_hold_a) else $error("hold high on A not applied");
  property p_hold_b; $past(reg_rd) && $past(reg_addr) == 4'h1 && reg_rdata[3:2] == 2'h1
    ##1 time_base_clock |=> !pwm_out_b; endproperty
  a_hold_b: assert property (p_hold_b) else $error("hold low on B not applied");
  property p_os_a_set; reg_wr && reg_addr == 4'h0 && reg_wdata[2:0] == 3'h6
    ##3 time_base_clock |=> pwm_out_a; endproperty
  a_os_a_set: assert property (p_os_a_set) else $error("one-shot set on A lost");
  property p_os_a_tog; reg_wr && reg_addr == 4'h0 && reg_wdata[2:0] == 3'h7
    ##3 time_base_clock |=> pwm_out_a != $past(pwm_out_a); endproperty
  a_os_a_tog: assert property (p_os_a_tog) else $error("one-shot toggle on A lost");
  property p_os_b_clr; reg_wr && reg_addr == 4'h0 && reg_wdata[5:3] == 3'h5
    ##3 time_base_clock |=> !pwm_out_b; endproperty
  a_os_b_clr: assert property (p_os_b_clr) else $error("one-shot clear on B lost");
  property p_os_b_set; reg_wr && reg_addr == 4'h0 && reg_wdata[5:3] == 3'h6
    ##3 time_base_clock |=> pwm_out_b; endproperty
  a_os_b_set: assert property (p_os_b_set) else $error("one-shot set on B lost");
  c_hold_wr: cover property (reg_wr && reg_addr == 4'h1);
  c_rise_b: cover property ($rose(pwm_out_b));
  c_fall_a: cover property ($fell(pwm_out_a));
endmodule
bind pwmsf_top pwmsf_monitor u_mon (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .time_base_clock(time_base_clock), .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b));
`default_nettype wire

// *** verif/pwm_software_force_qualifier_test.sv ***
// Self-checking testbench of the software-force qualifier.
`default_nettype none
module pwm_software_force_qualifier_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, arst_n, reg_wr, reg_rd, time_base_clock, cnt_zero, cnt_period;
  logic        pwm_out_a, pwm_out_b, la, lb;
  logic [3:0]  reg_addr, qual_action;
  logic [15:0] reg_wdata, reg_rdata;
  logic [1:0]  act_a [5] = '{2'h2, 2'h3, 2'h1, 2'h3, 2'h0};
  logic [1:0]  act_b [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h3};
  logic [1:0]  sel [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
  int          fails = 0, cmp_count = 0, cyc = 0, i;

  pwmsf_top dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .time_base_clock(time_base_clock), .cnt_zero(cnt_zero), .cnt_period(cnt_period),
    .qual_action(qual_action), .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task end_sim;
    if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // The whole sequence needs under 150 cycles; a hang stops well past that.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      fails++;
      end_sim();
    end
  end

  task ck(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Outputs are looked at on the falling edge, where they are settled.
  task co(input logic b, input logic a);
    @(negedge clk);
    ck({14'h0000, pwm_out_b, pwm_out_a}, {14'h0000, b, a});
    @(posedge clk);
  endtask

  task wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task rd(input logic [3:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    ck(reg_rdata, e);
    @(posedge clk);
  endtask

  task tk(input logic z, input logic p, input logic [3:0] q);
    time_base_clock <= 1'b1;
    cnt_zero <= z;
    cnt_period <= p;
    qual_action <= q;
    @(posedge clk);
    time_base_clock <= 1'b0;
    cnt_zero <= 1'b0;
    cnt_period <= 1'b0;
    qual_action <= 4'h0;
    @(posedge clk);
  endtask

  function automatic logic nx(input logic l, input logic [1:0] c);
    return (c == 2'h3) ? !l : (c == 2'h0) ? l : (c == 2'h2);
  endfunction

  initial begin
    {arst_n, reg_wr, reg_rd, time_base_clock, cnt_zero, cnt_period, la, lb} = 8'h00;
    reg_addr = 4'h0;
    qual_action = 4'h0;
    reg_wdata = 16'h0000;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(4'h0, 16'h0000);
    rd(4'h1, 16'h0000);
    for (i = 0; i < 5; i++) begin
      wr(4'h0, {10'h000, 1'b1, act_b[i], 1'b1, act_a[i]});
      co(lb, la);
      la = nx(la, act_a[i]);
      lb = nx(lb, act_b[i]);
      tk(i[0], !i[0], 4'h0);
      co(lb, la);
    end
    rd(4'h0, 16'h0018);
    wr(4'h0, 16'h0019);
    tk(1'b0, 1'b0, 4'h0);
    co(1'b1, 1'b1);
    tk(1'b0, 1'b0, 4'h5);
    co(1'b0, 1'b0);
    tk(1'b0, 1'b0, 4'h8);
    wr(4'h0, 16'h00C0);
    wr(4'h1, 16'h0006);
    co(1'b1, 1'b0);
    rd(4'h1, 16'h0006);
    tk(1'b0, 1'b0, 4'h0);
    co(1'b0, 1'b1);
    wr(4'h1, 16'h000F);
    tk(1'b0, 1'b0, 4'h0);
    co(1'b1, 1'b0);
    for (i = 0; i < 4; i++) begin
      wr(4'h0, {8'h00, sel[i], 6'h00});
      wr(4'h1, i[0] ? 16'h000F : 16'h0006);
      tk(sel[i] == 2'h1, sel[i] == 2'h0, 4'h0);
      rd(4'h1, i[0] ? 16'h0006 : 16'h000F);
      tk(!i[0], i[0], 4'h0);
      co(!i[0], i[0]);
      rd(4'h1, i[0] ? 16'h000F : 16'h0006);
      tk(1'b0, 1'b0, 4'h0);
      co(i[0], !i[0]);
    end
    wr(4'hF, 16'hFFFF);
    rd(4'hF, 16'h0000);
    rd(4'h1, 16'h000F);
    // A trigger written on a tick edge must survive that tick and act on the next one.
    reg_addr <= 4'h0;
    reg_wdata <= 16'h0006;
    reg_wr <= 1'b1;
    time_base_clock <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    time_base_clock <= 1'b0;
    @(posedge clk);
    co(1'b1, 1'b0);
    tk(1'b0, 1'b0, 4'h0);
    co(1'b1, 1'b1);
    rd(4'h2, 16'h00FC);
    end_sim();
  end
endmodule
`default_nettype wire
